// File: src/psp_pkg.sv
/*
 * package for the parallel slave port: register offsets, field positions,
 * reset values, phase timing and the pin carrier structs.
 * assumes an apb slave at 32-bit data, one register per aligned word.
 */
package psp_pkg;

	// ------------------------------------------------------------------
	// register indices (printed offsets) and byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0]  IDX_PORT_D_DATA   = 8'h08;
	localparam logic [7:0]  IDX_PORT_E_PIN    = 8'h09;
	localparam logic [7:0]  IDX_IRQ_FLAGS_1   = 8'h0C;
	localparam logic [7:0]  IDX_PORT_E_DIR    = 8'h89;
	localparam logic [7:0]  IDX_IRQ_ENABLES_1 = 8'h8C;
	localparam logic [7:0]  IDX_ANALOG_CFG    = 8'h9F;
	localparam logic [7:0]  IDX_PORT_D_DIR    = 8'h88;
	localparam logic [11:0] ADDR_PORT_D_DATA   = {2'h0, IDX_PORT_D_DATA, 2'h0};
	localparam logic [11:0] ADDR_PORT_E_PIN    = {2'h0, IDX_PORT_E_PIN, 2'h0};
	localparam logic [11:0] ADDR_IRQ_FLAGS_1   = {2'h0, IDX_IRQ_FLAGS_1, 2'h0};
	localparam logic [11:0] ADDR_PORT_E_DIR    = {2'h0, IDX_PORT_E_DIR, 2'h0};
	localparam logic [11:0] ADDR_IRQ_ENABLES_1 = {2'h0, IDX_IRQ_ENABLES_1, 2'h0};
	localparam logic [11:0] ADDR_ANALOG_CFG    = {2'h0, IDX_ANALOG_CFG, 2'h0};
	localparam logic [11:0] ADDR_PORT_D_DIR    = {2'h0, IDX_PORT_D_DIR, 2'h0};

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int          BIT_IN_FULL   = 7;
	localparam int          BIT_OUT_FULL  = 6;
	localparam int          BIT_IN_OVF    = 5;
	localparam int          BIT_MODE      = 4;
	localparam int          BIT_XFER_IRQ  = 7;
	localparam logic [2:0]  RST_PORT_E_DIR = 3'h7;
	localparam logic [7:0]  RST_PORT_D_DIR = 8'hFF;
	localparam logic [7:0]  RST_IRQ_ENA    = 8'h00;
	localparam logic [4:0]  RST_ANALOG_CFG = 5'h00;
	localparam logic [3:0]  ANALOG_MASK    = 4'hF;

	// ------------------------------------------------------------------
	// phase clock: four pclk cycles per instruction cycle
	// ------------------------------------------------------------------
	localparam logic [1:0]  PHASE_SECOND  = 2'h1;
	localparam logic [1:0]  PHASE_FOURTH  = 2'h3;

	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} psp_strobe_t;

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} psp_bus_out_t;

endpackage : psp_pkg

// File: src/psp_slave_port.sv
/*
 * parallel slave port with apb register access: byte latches, status
 * flags, transfer interrupt and port d/e pin control.
 * assumes the external strobes are asynchronous to pclk and the pin data
 * is stable while its write strobe is low.
 */
// The implementer's own choice: the APB interface to the registers.
// Summary of operation
// (R01) mode select bit turns port d into an 8-bit external slave data port
// (R02) in slave mode port e pins become read, write and select inputs
// (R03) external transfers are driven only by the strobe and select pins
// (R04) two latches at one address: writes load output, reads return input
// (R05) port d direction register is ignored in slave mode
// (R06) a write begins once select and write strobe are both low
// (R07) write end sets input-full on the q4 after the next q2
// (R08) write end sets the transfer interrupt flag on that same q4
// (R09) input-full clears only when firmware reads the input latch
// (R10) second external write before firmware read sets the overflow flag
// (R11) read start, select and read strobe low, clears output-full at once
// (R12) read end sets the transfer interrupt flag on q4 after next q2
// (R13) output-full stays low until firmware writes the output latch
// (R14) outside slave mode full flags clear; overflow kept until cleared
// (R15) interrupt flag sticky until cleared; enable bit gates the request
// (R16) external master treats select and strobes as active low
// (R17) data pins driven only while select and read strobe are low; here the enable trails the strobes by three cycles
// (R18) strobes pass two-stage synchronisers before any flag logic
`timescale 1ns/1ps

module psp_slave_port (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       irq,
	input  wire psp_pkg::psp_strobe_t  strobe_in,
	input  wire logic [7:0]            port_d_in,
	output psp_pkg::psp_bus_out_t      port_d_out,
	output logic      [2:0]            port_e_out,
	output logic      [2:0]            port_e_oe
);
	import psp_pkg::*;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0]  out_latch_q;
	logic [7:0]  in_latch_q;
	logic [7:0]  port_d_dir_q;
	logic [2:0]  port_e_dir_q;
	logic [2:0]  port_e_lat_q;
	logic        mode_q;
	logic        in_full_q;
	logic        out_full_q;
	logic        in_ovf_q;
	logic        xfer_irq_q;
	logic [7:0]  irq_ena_q;
	logic [4:0]  analog_cfg_q;
	logic [1:0]  phase_q;
	logic        pend_wr_q;
	logic        pend_rd_q;
	logic        seen_ph2_wr_q;
	logic        seen_ph2_rd_q;
	psp_strobe_t sync1_q;
	psp_strobe_t sync2_q;
	psp_strobe_t sync2_prev_q;
	logic [7:0]  din1_q;
	logic [7:0]  din2_q;
	logic [2:0]  pin_e1_q;
	logic [2:0]  pin_e2_q;

	// ------------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------------
	// port e pins get their own pair for register reads; the strobe pair feeds the flags, the input latch and the port d output enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q      <= '1;
			sync2_q      <= '1;
			sync2_prev_q <= '1;
			din1_q       <= 8'h00;
			din2_q       <= 8'h00;
			pin_e1_q     <= 3'h0;
			pin_e2_q     <= 3'h0;
		end else begin
			sync1_q      <= strobe_in;                      // R18
			sync2_q      <= sync1_q;                        // R18
			sync2_prev_q <= sync2_q;
			din1_q       <= port_d_in;
			din2_q       <= din1_q;
			pin_e1_q     <= {strobe_in.cs_n, strobe_in.wr_n, strobe_in.rd_n};
			pin_e2_q     <= pin_e1_q;
		end
	end

	// ------------------------------------------------------------------
	// edge detection
	// ------------------------------------------------------------------
	// strobes are active low; the master drives them high when idle
	logic wr_act;
	logic wr_act_prev;
	logic rd_act;
	logic rd_act_prev;
	logic wr_start;
	logic wr_end;
	logic rd_start;
	logic rd_end;
	assign wr_act      = mode_q & ~sync2_q.cs_n & ~sync2_q.wr_n;         // R06 R16
	assign wr_act_prev = mode_q & ~sync2_prev_q.cs_n & ~sync2_prev_q.wr_n;
	assign rd_act      = mode_q & ~sync2_q.cs_n & ~sync2_q.rd_n;         // R11 R16
	assign rd_act_prev = mode_q & ~sync2_prev_q.cs_n & ~sync2_prev_q.rd_n;
	assign wr_start    = wr_act & ~wr_act_prev;                          // R03
	assign wr_end      = ~wr_act & wr_act_prev;                          // R07
	assign rd_start    = rd_act & ~rd_act_prev;                          // R11
	assign rd_end      = ~rd_act & rd_act_prev;                          // R12

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	logic acc;
	logic wr_en;
	logic rd_en;
	logic hit;
	assign acc   = psel & penable;
	assign wr_en = acc & pwrite;
	assign rd_en = acc & ~pwrite;
	always_comb begin
		unique case (paddr)
			ADDR_PORT_D_DATA, ADDR_PORT_E_PIN, ADDR_IRQ_FLAGS_1, ADDR_PORT_E_DIR,
			ADDR_IRQ_ENABLES_1, ADDR_ANALOG_CFG, ADDR_PORT_D_DIR: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// unmapped or misaligned addresses answer with pslverr and change nothing
	logic fw_wr_data;
	logic fw_rd_data;
	logic fw_wr_dir_e;
	logic fw_wr_flags;
	assign fw_wr_data  = wr_en & hit & (paddr == ADDR_PORT_D_DATA);
	assign fw_rd_data  = rd_en & hit & (paddr == ADDR_PORT_D_DATA);
	assign fw_wr_dir_e = wr_en & (paddr == ADDR_PORT_E_DIR);
	assign fw_wr_flags = wr_en & (paddr == ADDR_IRQ_FLAGS_1);

	// ------------------------------------------------------------------
	// phase counter: q2 and q4 of each four-cycle instruction period
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// ------------------------------------------------------------------
	// completion timing
	// ------------------------------------------------------------------
	// the counter free-runs, so a completion lands 3 to 6 cycles after the synced release
	// a completion waits for a q2, then lands on the following q4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_wr_q     <= 1'b0;
			seen_ph2_wr_q <= 1'b0;
		end else begin
			if (wr_end) begin
				pend_wr_q     <= 1'b1;
				seen_ph2_wr_q <= 1'b0;
			end else if (pend_wr_q && phase_q == PHASE_SECOND) begin
				seen_ph2_wr_q <= 1'b1;
			end else if (seen_ph2_wr_q && phase_q == PHASE_FOURTH) begin
				pend_wr_q     <= 1'b0;
				seen_ph2_wr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_rd_q     <= 1'b0;
			seen_ph2_rd_q <= 1'b0;
		end else begin
			if (rd_end) begin
				pend_rd_q     <= 1'b1;
				seen_ph2_rd_q <= 1'b0;
			end else if (pend_rd_q && phase_q == PHASE_SECOND) begin
				seen_ph2_rd_q <= 1'b1;
			end else if (seen_ph2_rd_q && phase_q == PHASE_FOURTH) begin
				pend_rd_q     <= 1'b0;
				seen_ph2_rd_q <= 1'b0;
			end
		end
	end

	logic wr_done;
	logic rd_done;
	assign wr_done = seen_ph2_wr_q & (phase_q == PHASE_FOURTH) & ~wr_end;   // R07
	assign rd_done = seen_ph2_rd_q & (phase_q == PHASE_FOURTH) & ~rd_end;   // R12

	// ------------------------------------------------------------------
	// data latches
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_latch_q <= 8'h00;
			in_latch_q  <= 8'h00;
		end else begin
			if (fw_wr_data) begin
				out_latch_q <= pwdata[7:0];                    // R04
			end
			// not held off by the full flag: a late write overwrites, overflow records it
			// sampled while the strobe is still low, data is stable there
			if (wr_act) begin
				in_latch_q <= din2_q;                          // R04 R03
			end
		end
	end

	// ------------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------------
	// set wins over a firmware read in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_full_q <= 1'b0;
		end else if (!mode_q) begin
			in_full_q <= 1'b0;                                 // R14
		end else if (wr_done) begin
			in_full_q <= 1'b1;                                 // R07
		end else if (fw_rd_data) begin
			in_full_q <= 1'b0;                                 // R09
		end
	end

	// a host read start wins: firmware must refill the latch after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_full_q <= 1'b0;
		end else if (!mode_q) begin
			out_full_q <= 1'b0;                                // R14
		end else if (rd_start) begin
			out_full_q <= 1'b0;                                // R11
		end else if (fw_wr_data) begin
			out_full_q <= 1'b1;                                // R13
		end
	end

	// set wins over a firmware clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_ovf_q <= 1'b0;
		end else if (wr_start && in_full_q) begin
			in_ovf_q <= 1'b1;                                  // R10
		end else if (fw_wr_dir_e && !pwdata[BIT_IN_OVF]) begin
			in_ovf_q <= 1'b0;                                  // R14
		end
	end

	// ------------------------------------------------------------------
	// transfer interrupt: sticky, cleared by writing one
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_irq_q <= 1'b0;
			irq        <= 1'b0;
		end else begin
			if (wr_done || rd_done) begin
				xfer_irq_q <= 1'b1;                            // R08 R12
			end else if (fw_wr_flags && pwdata[BIT_XFER_IRQ]) begin
				xfer_irq_q <= 1'b0;                            // R15
			end
			irq <= xfer_irq_q & irq_ena_q[BIT_XFER_IRQ];       // R15
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q       <= 1'b0;
			port_e_dir_q <= RST_PORT_E_DIR;
			port_d_dir_q <= RST_PORT_D_DIR;
			port_e_lat_q <= 3'h0;
			irq_ena_q    <= RST_IRQ_ENA;
			analog_cfg_q <= RST_ANALOG_CFG;
		end else if (wr_en) begin
			unique case (paddr)
				// direction bits stay writable in slave mode; port e pins are inputs and port d follows the read strobe anyway
				ADDR_PORT_E_DIR: begin
					mode_q       <= pwdata[BIT_MODE];          // R01
					port_e_dir_q <= pwdata[2:0];
				end
				ADDR_PORT_D_DIR:    port_d_dir_q <= pwdata[7:0];
				ADDR_PORT_E_PIN:    port_e_lat_q <= pwdata[2:0];
				ADDR_IRQ_ENABLES_1: irq_ena_q    <= pwdata[7:0];
				ADDR_ANALOG_CFG:    analog_cfg_q <= {pwdata[7], pwdata[3:0]};
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pins: slave mode overrides both direction registers
	// ------------------------------------------------------------------
	// an all-analog setting makes the port e pins read as zero
	logic e_digital;
	assign e_digital = ((analog_cfg_q[3:0] & ANALOG_MASK) != 4'h0);
	// the enable trails the pins by three cycles; a host must leave that gap
	// between a read and its next write, or both sides drive the bus
	logic rd_drive;
	assign rd_drive = ~sync2_q.cs_n & ~sync2_q.rd_n;                   // R17 R18
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_d_out <= '0;
			port_e_out <= 3'h0;
			port_e_oe  <= 3'h0;
		end else begin
			port_d_out.dout <= out_latch_q;
			if (mode_q) begin
				// synchronised strobes only, so a metastable pin never reaches a pad
				port_d_out.oe <= {8{rd_drive}};                            // R17 R05
				port_e_oe     <= 3'h0;                                     // R02
			end else begin
				port_d_out.oe <= ~port_d_dir_q;
				port_e_oe     <= ~port_e_dir_q;
			end
			port_e_out <= port_e_lat_q;
		end
	end

	// ------------------------------------------------------------------
	// apb read path and answer, zero wait states
	// ------------------------------------------------------------------
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		unique case (paddr)
			ADDR_PORT_D_DATA:   rd_byte = mode_q ? in_latch_q : din2_q;    // R04
			ADDR_PORT_E_PIN:    rd_byte = {5'h00, e_digital ? pin_e2_q : 3'h0};
			ADDR_IRQ_FLAGS_1:   rd_byte[BIT_XFER_IRQ] = xfer_irq_q;
			ADDR_PORT_E_DIR: begin
				rd_byte[BIT_IN_FULL]  = in_full_q;
				rd_byte[BIT_OUT_FULL] = out_full_q;
				rd_byte[BIT_IN_OVF]   = in_ovf_q;
				rd_byte[BIT_MODE]     = mode_q;
				rd_byte[2:0]          = port_e_dir_q;
			end
			ADDR_IRQ_ENABLES_1: rd_byte = irq_ena_q;
			ADDR_ANALOG_CFG:    rd_byte = {analog_cfg_q[4], 3'h0, analog_cfg_q[3:0]};
			ADDR_PORT_D_DIR:    rd_byte = port_d_dir_q;
			default:            rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// answer registered from the setup phase, so every access completes with zero wait states
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			prdata  <= {24'h000000, rd_byte};
		end
	end

endmodule : psp_slave_port

// File: tb/psp_slave_port_sva.sv
/* checker: bus, data-pin enable and interrupt relations of the slave port.
 * assumes it is bound into psp_slave_port and sees only that module's ports. */
`timescale 1ns/1ps
module psp_slave_port_sva (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  irq,
	input wire psp_pkg::psp_strobe_t  strobe_in,
	input wire logic [7:0]            port_d_in,
	input wire psp_pkg::psp_bus_out_t port_d_out,
	input wire logic [2:0]            port_e_out,
	input wire logic [2:0]            port_e_oe
);
	import psp_pkg::*;
	logic fw_wr;
	logic wr_irq;
	logic mode_q;
	logic ena_q;
	assign fw_wr  = psel && penable && pready && pwrite && !pslverr;
	assign wr_irq = fw_wr && (paddr == ADDR_IRQ_FLAGS_1 || paddr == ADDR_IRQ_ENABLES_1);
	// mode and enable are shadowed from taken writes, since the checker sees no internals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 1'b0;
			ena_q  <= 1'b0;
		end else if (fw_wr) begin
			if (paddr == ADDR_PORT_E_DIR) mode_q <= pwdata[BIT_MODE];
			if (paddr == ADDR_IRQ_ENABLES_1) ena_q <= pwdata[BIT_XFER_IRQ];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rdata_byte: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read data above byte");
	chk_oe_only_read: assert property (mode_q && $past(mode_q) && port_d_out.oe != 8'h00
		|-> $past(!strobe_in.cs_n && !strobe_in.rd_n, 3)) else $error("pins driven off read");
	chk_oe_on_read: assert property (mode_q && $past(mode_q)
		&& $past(!strobe_in.cs_n && !strobe_in.rd_n, 3) |-> port_d_out.oe == 8'hFF)
		else $error("pins not driven on read");
	chk_irq_masked: assert property (!ena_q && !$past(ena_q) |-> !irq)
		else $error("irq while disabled");
	chk_irq_sticky: assert property (irq && !wr_irq && !$past(wr_irq) |=> irq)
		else $error("irq dropped uncleared");
	chk_irq_xfer_end: assert property (mode_q && ena_q && $rose(strobe_in.cs_n)
		&& !$past(strobe_in.wr_n && strobe_in.rd_n) |-> ##[2:12] irq)
		else $error("no irq after transfer");
endmodule : psp_slave_port_sva

bind psp_slave_port psp_slave_port_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .strobe_in(strobe_in),
	.port_d_in(port_d_in), .port_d_out(port_d_out), .port_e_out(port_e_out),
	.port_e_oe(port_e_oe));

// File: tb/psp_host_model.sv
/* model of the external byte-wide host: select, strobes and data lines.
 * assumes the bench resolves the shared data pins and feeds them back. */
`timescale 1ns/1ps
module psp_host_model (
	input  wire logic            pclk,
	input  wire logic [7:0]      pin_d,
	output psp_pkg::psp_strobe_t strobe,
	output logic      [7:0]      host_d
);
	import psp_pkg::*;
	initial begin
		strobe = 3'h7;
		host_d = 8'h00;
	end
	task automatic ext_write(input logic [7:0] b);
		@(posedge pclk);
		host_d <= b;
		strobe <= 3'h1;
		repeat (4) @(posedge pclk);
		strobe <= 3'h7;
		// data held past release to cover the select synchroniser
		repeat (3) @(posedge pclk);
		host_d <= ~b;
	endtask : ext_write
	task automatic ext_read(output logic [7:0] b);
		@(posedge pclk);
		strobe <= 3'h2;
		repeat (4) @(posedge pclk);
		b = pin_d;
		strobe <= 3'h7;
	endtask : ext_read
endmodule : psp_host_model

// File: tb/test_parallel_slave_port.sv
/* bench: apb register tasks plus the host model on the port d/e pins.
 * assumes psp_pkg, the design top and the host model are compiled first. */
`timescale 1ns/1ps
module test_parallel_slave_port;
	import psp_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rdv;
	logic [7:0]   host_d, pin_d, rd_b;
	logic [2:0]   e_out, e_oe;
	psp_strobe_t  strobe;
	psp_bus_out_t d_out;
	int           num_errors, n_checks;
	// a pin is the device's byte where it drives, else whatever the host puts there
	assign pin_d = (d_out.oe & d_out.dout) | (~d_out.oe & host_d);
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	psp_slave_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .strobe_in(strobe), .port_d_in(pin_d),
		.port_d_out(d_out), .port_e_out(e_out), .port_e_oe(e_oe));
	psp_host_model u_host (.pclk(pclk), .pin_d(pin_d), .strobe(strobe), .host_d(host_d));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic apb_xfer(input logic [11:0] a, input logic wr, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
		end
		rdv = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb_xfer(a, 1'b0, 32'h0);
		check(what, exp, rdv);
	endtask : rd_chk
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, presetn, paddr, pwdata} = '0;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(ADDR_PORT_E_DIR, 32'h07, "status reset");
		rd_chk(ADDR_IRQ_FLAGS_1, 32'h00, "flags reset");
		rd_chk(ADDR_IRQ_ENABLES_1, 32'h00, "enables reset");
		rd_chk(12'h004, 32'h00, "unmapped read");
		check("unmapped err", 32'h1, {31'h0, err});
		apb_xfer(ADDR_PORT_E_DIR, 1'b1, 32'h17);
		apb_xfer(ADDR_IRQ_ENABLES_1, 1'b1, 32'h80);
		apb_xfer(ADDR_PORT_D_DATA, 1'b1, 32'h5A);
		rd_chk(ADDR_PORT_E_DIR, 32'h57, "obf set");
		u_host.ext_read(rd_b);
		check("pins on read", 32'h5A, {24'h0, rd_b});
		repeat (12) @(posedge pclk);
		rd_chk(ADDR_PORT_E_DIR, 32'h17, "obf after read");
		check("irq read end", 32'h1, {31'h0, irq});
		rd_chk(ADDR_IRQ_FLAGS_1, 32'h80, "flag read end");
		apb_xfer(ADDR_IRQ_FLAGS_1, 1'b1, 32'h80);
		repeat (2) @(posedge pclk);
		check("irq cleared", 32'h0, {31'h0, irq});
		u_host.ext_write(8'h3C);
		repeat (12) @(posedge pclk);
		rd_chk(ADDR_PORT_E_DIR, 32'h97, "ibf set");
		rd_chk(ADDR_IRQ_FLAGS_1, 32'h80, "flag write end");
		u_host.ext_write(8'hC3);
		repeat (12) @(posedge pclk);
		rd_chk(ADDR_PORT_E_DIR, 32'hB7, "overflow");
		rd_chk(ADDR_PORT_D_DATA, 32'hC3, "input latch");
		rd_chk(ADDR_PORT_E_DIR, 32'h37, "ibf cleared");
		apb_xfer(ADDR_IRQ_FLAGS_1, 1'b1, 32'h80);
		apb_xfer(ADDR_IRQ_ENABLES_1, 1'b1, 32'h00);
		u_host.ext_write(8'h66);
		repeat (12) @(posedge pclk);
		check("irq masked", 32'h0, {31'h0, irq});
		rd_chk(ADDR_IRQ_FLAGS_1, 32'h80, "flag masked");
		apb_xfer(ADDR_PORT_D_DIR, 1'b1, 32'h00);
		repeat (2) @(posedge pclk);
		check("dir ignored", 32'h0, {24'h0, d_out.oe});
		apb_xfer(ADDR_PORT_D_DATA, 1'b1, 32'h11);
		apb_xfer(ADDR_PORT_E_DIR, 1'b1, 32'h27);
		rd_chk(ADDR_PORT_E_DIR, 32'h27, "gpio flags");
		apb_xfer(ADDR_PORT_E_DIR, 1'b1, 32'h07);
		rd_chk(ADDR_PORT_E_DIR, 32'h07, "overflow cleared");
		apb_xfer(ADDR_PORT_E_DIR, 1'b1, 32'h10);
		repeat (2) @(posedge pclk);
		check("e pins in slave mode", 32'h0, {29'h0, e_oe});
		apb_xfer(ADDR_PORT_E_DIR, 1'b1, 32'h02);
		apb_xfer(ADDR_PORT_E_PIN, 1'b1, 32'h05);
		repeat (2) @(posedge pclk);
		check("e pin enables", 32'h5, {29'h0, e_oe});
		check("e pin latch", 32'h5, {29'h0, e_out});
		rd_chk(ADDR_PORT_E_PIN, 32'h00, "e pins analog");
		apb_xfer(ADDR_ANALOG_CFG, 1'b1, 32'h06);
		rd_chk(ADDR_PORT_E_PIN, 32'h07, "e pins digital");
		give_verdict();
	end
	// a hung handshake ends the run through the same verdict
	initial begin
		#150000;
		num_errors++;
		give_verdict();
	end
endmodule : test_parallel_slave_port
